// ---- irq_prio_pkg.sv ----
package irq_prio_pkg;

	// Vector addresses
	localparam logic [15:0] VEC_HIGH      = 16'h0008;
	localparam logic [15:0] VEC_LOW       = 16'h0018;
	localparam logic [15:0] VEC_NONE      = 16'h0000;

	// Source count and index of the external zero source
	localparam int          NUM_SRC       = 8;
	localparam int          EXT0_IDX      = 0;

	// Reset values
	localparam logic        PRIO_EN_RST   = 1'b0;
	localparam logic        GEN_EN_RST    = 1'b0;

	// Service level state
	typedef enum logic [1:0] {
		LVL_IDLE,
		LVL_LOW,
		LVL_HIGH,
		LVL_HIGH_OVER_LOW
	} lvl_t;

endpackage : irq_prio_pkg

// ---- irq_flag_bank.sv ----
`timescale 1ns/1ps
// Sticky event flags: set by hardware, cleared by software, set wins
module irq_flag_bank #(
	parameter int N = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Events, clears and software sets
	input  wire logic [N-1:0] event_in,
	input  wire logic [N-1:0] flag_clr,
	input  wire logic [N-1:0] flag_set,
	// Flags
	output logic      [N-1:0] flag_q
);

	logic [N-1:0] flag_d;

	// Set independent of any enable; set beats clear
	assign flag_d = (flag_q & ~flag_clr) | event_in | flag_set; // [R17]

	// Flag register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flag_q <= '0;
		else
			flag_q <= flag_d;
	end

	// Parameter check at elaboration
	generate
		if (N < 1)
		begin : g_bad_width
			$error("irq_flag_bank: N must be at least 1");
		end
	endgenerate

endmodule : irq_flag_bank

// ---- two_level_interrupt_priority_ctrl.sv ----
`timescale 1ns/1ps
// Functional notes
// [R1] External source zero always high priority
// [R2] High vector 0008h, low vector 0018h
// [R3] High request preempts running low routine
// [R4] Each source: flag, enable, priority bit
// [R5] Reset clears priority levels enable
// [R6] Compatibility mode ignores priority bits
// [R7] Peripheral needs peripheral and global enable
// [R8] Global enable gates all sources
// [R9] Compatibility mode always vectors to 0008h
// [R10] Priority enable turns enables into levels
// [R11] High enable passes high priority sources
// [R12] Cleared high enable masks every source
// [R13] Cleared low enable masks low only
// [R14] Low sources need both level enables
// [R15] Accepted request vectors by its priority
// [R16] Acceptance clears the applicable enable
// [R17] Flags set regardless of enables
// [R18] Return sets applicable enable again
// [R19] No low service during high routine
// [R20] Simultaneous requests: high goes first
module two_level_interrupt_priority_ctrl #(
	parameter int                  NUM_SRC    = irq_prio_pkg::NUM_SRC,
	parameter logic [NUM_SRC-1:0]  PERIPH_MAP = 8'hF0
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// Interrupt source events, one-cycle pulses on clk
	input  wire logic [NUM_SRC-1:0] src_event,
	// Software writes to flags, enables and priorities
	input  wire logic [NUM_SRC-1:0] flag_clr,
	input  wire logic [NUM_SRC-1:0] flag_set,
	input  wire logic               enable_wr,
	input  wire logic [NUM_SRC-1:0] enable_wdata,
	input  wire logic               prio_wr,
	input  wire logic [NUM_SRC-1:0] prio_wdata,
	// Reset control register: priority levels enable
	input  wire logic               prio_en_wr,
	input  wire logic               prio_en_wdata,
	// Global enable writes (irq_control_reg bits)
	input  wire logic               gen_wr,
	input  wire logic               global_or_high_wdata,
	input  wire logic               periph_or_low_wdata,
	// Core handshake
	input  wire logic               core_ack,
	input  wire logic               return_from_irq_instr,
	output logic                    irq_req,
	output logic [15:0]             irq_vector,
	// Status
	output logic [NUM_SRC-1:0]      flag_q,
	output logic [NUM_SRC-1:0]      enable_q,
	output logic [NUM_SRC-1:0]      prio_q,
	output logic                    priority_levels_enable,
	output logic                    global_or_high_level_enable,
	output logic                    peripheral_or_low_level_enable,
	output logic                    in_high_service,
	output logic                    in_low_service
);

	// Registers
	logic [NUM_SRC-1:0] enable_d;
	logic [NUM_SRC-1:0] prio_d;
	logic               prio_en_q;
	logic               prio_en_d;
	logic               gen_hi_q;
	logic               gen_hi_d;
	logic               gen_lo_q;
	logic               gen_lo_d;
	irq_prio_pkg::lvl_t lvl_q;
	irq_prio_pkg::lvl_t lvl_d;
	logic [15:0]        vec_q;
	logic [15:0]        vec_d;

	// Decode wires
	logic [NUM_SRC-1:0] eff_prio;
	logic [NUM_SRC-1:0] pend;
	logic [NUM_SRC-1:0] hi_ok;
	logic [NUM_SRC-1:0] lo_ok;
	logic               hi_req;
	logic               lo_req;
	logic               take_hi;
	logic               take_lo;
	logic               accept_hi;
	logic               accept_lo;
	logic               ret_hi;
	logic               ret_lo;
	logic               high_busy;
	logic               low_busy;
	logic [NUM_SRC-1:0] is_periph;
	logic [NUM_SRC-1:0] periph_gate;
	logic [NUM_SRC-1:0] compat_ok;
	logic [NUM_SRC-1:0] prio_hi_ok;
	logic [NUM_SRC-1:0] prio_lo_ok;

	// Sticky flag bank
	irq_flag_bank #(
		.N        (NUM_SRC)
	) u_flags (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.event_in (src_event),
		.flag_clr (flag_clr),
		.flag_set (flag_set),
		.flag_q   (flag_q)
	);

	// Effective priority: source zero forced high
	function automatic logic [NUM_SRC-1:0] fix_prio(input logic [NUM_SRC-1:0] p);
		logic [NUM_SRC-1:0] r;
		r = p;
		r[irq_prio_pkg::EXT0_IDX] = 1'b1; // [R1]
		return r;
	endfunction : fix_prio

	assign eff_prio = fix_prio(prio_q);
	assign pend     = flag_q & enable_q; // [R4]

	// Eligibility per source, per mode
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_elig
			// In compatibility mode, peripheral sources also need the peripheral enable
			assign is_periph[gi]   = PERIPH_MAP[gi];
			assign periph_gate[gi] = ~is_periph[gi] | gen_lo_q; // [R7]
			// Compatibility: one level, priority bits ignored
			assign compat_ok[gi]   = pend[gi] & gen_hi_q & periph_gate[gi]; // [R6] [R7] [R8]
			// Priority mode: high needs high enable, low needs both
			assign prio_hi_ok[gi]  = pend[gi] & eff_prio[gi] & gen_hi_q; // [R11] [R12]
			assign prio_lo_ok[gi]  = pend[gi] & ~eff_prio[gi] & gen_hi_q & gen_lo_q; // [R13] [R14]
			// Mode selects which set reaches the arbiter
			assign hi_ok[gi]       = prio_en_q ? prio_hi_ok[gi] : compat_ok[gi]; // [R10]
			assign lo_ok[gi]       = prio_en_q & prio_lo_ok[gi];
		end
	endgenerate

	// Level state decode, shared by both service flags
	function automatic logic lvl_has(input irq_prio_pkg::lvl_t s, input logic want_high);
		logic hit;
		hit = 1'b0;
		case (s)
			irq_prio_pkg::LVL_HIGH:          hit = want_high;
			irq_prio_pkg::LVL_LOW:           hit = ~want_high;
			irq_prio_pkg::LVL_HIGH_OVER_LOW: hit = 1'b1;
			default:                         hit = 1'b0;
		endcase
		return hit;
	endfunction : lvl_has

	assign high_busy = lvl_has(lvl_q, 1'b1);
	assign low_busy  = lvl_has(lvl_q, 1'b0);

	// Request arbitration: high first, high preempts low, low blocked in high
	assign hi_req  = |hi_ok;
	assign lo_req  = |lo_ok;
	assign take_hi = hi_req & ~high_busy; // [R3] [R20]
	assign take_lo = lo_req & ~hi_req & ~high_busy & ~low_busy; // [R19] [R20]

	assign irq_req    = take_hi | take_lo; // [R15]
	assign irq_vector = vec_q;
	assign accept_hi  = core_ack & take_hi;
	assign accept_lo  = core_ack & take_lo;

	// Return closes the innermost level
	assign ret_hi = return_from_irq_instr & high_busy;
	assign ret_lo = return_from_irq_instr & ~high_busy & low_busy;

	// Vector of a level; compatibility mode only offers the high path
	function automatic logic [15:0] vec_for(input logic hi, input logic lo);
		logic [15:0] v;
		v = irq_prio_pkg::VEC_NONE;
		if (hi)
			v = irq_prio_pkg::VEC_HIGH; // [R2] [R9]
		else if (lo)
			v = irq_prio_pkg::VEC_LOW; // [R2]
		return v;
	endfunction : vec_for

	// Vector for the request on offer
	assign vec_d = vec_for(take_hi, take_lo);

	// Enable and priority register next values
	assign enable_d  = enable_wr ? enable_wdata : enable_q;
	assign prio_d    = prio_wr ? prio_wdata : prio_q;
	assign prio_en_d = prio_en_wr ? prio_en_wdata : prio_en_q; // [R10]

	// Global enables: clear on accept, set on return, hardware wins over write
	always_comb
	begin
		gen_hi_d = gen_wr ? global_or_high_wdata : gen_hi_q;
		gen_lo_d = gen_wr ? periph_or_low_wdata : gen_lo_q;
		if (accept_hi)
			gen_hi_d = 1'b0; // [R16]
		else if (accept_lo)
			gen_lo_d = 1'b0; // [R16]
		if (ret_hi)
			gen_hi_d = 1'b1; // [R18]
		else if (ret_lo)
		begin
			if (prio_en_q)
				gen_lo_d = 1'b1; // [R18]
			else
				gen_hi_d = 1'b1; // [R18]
		end
	end

	// Service level tracking
	always_comb
	begin
		lvl_d = lvl_q;
		case (lvl_q)
			irq_prio_pkg::LVL_IDLE:
			begin
				if (accept_hi)
					lvl_d = irq_prio_pkg::LVL_HIGH;
				else if (accept_lo)
					lvl_d = irq_prio_pkg::LVL_LOW;
			end
			irq_prio_pkg::LVL_LOW:
			begin
				if (accept_hi)
					lvl_d = irq_prio_pkg::LVL_HIGH_OVER_LOW; // [R3]
				else if (ret_lo)
					lvl_d = irq_prio_pkg::LVL_IDLE;
			end
			irq_prio_pkg::LVL_HIGH:
			begin
				if (ret_hi)
					lvl_d = irq_prio_pkg::LVL_IDLE;
			end
			irq_prio_pkg::LVL_HIGH_OVER_LOW:
			begin
				if (ret_hi)
					lvl_d = irq_prio_pkg::LVL_LOW;
			end
			default:
				lvl_d = irq_prio_pkg::LVL_IDLE;
		endcase
	end

	// Per-source enable and priority registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			enable_q <= '0;
			prio_q   <= '1;
		end
		else
		begin
			enable_q <= enable_d;
			prio_q   <= prio_d;
		end
	end

	// Mode and level enable registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prio_en_q <= irq_prio_pkg::PRIO_EN_RST; // [R5]
			gen_hi_q  <= irq_prio_pkg::GEN_EN_RST;
			gen_lo_q  <= irq_prio_pkg::GEN_EN_RST;
		end
		else
		begin
			prio_en_q <= prio_en_d;
			gen_hi_q  <= gen_hi_d;
			gen_lo_q  <= gen_lo_d;
		end
	end

	// Service level and offered vector registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lvl_q <= irq_prio_pkg::LVL_IDLE;
			vec_q <= irq_prio_pkg::VEC_NONE;
		end
		else
		begin
			lvl_q <= lvl_d;
			vec_q <= vec_d;
		end
	end

	// Status outputs
	assign priority_levels_enable         = prio_en_q;
	assign global_or_high_level_enable    = gen_hi_q;
	assign peripheral_or_low_level_enable = gen_lo_q;
	assign in_high_service                = high_busy;
	assign in_low_service                 = low_busy;

	// Parameter checks at elaboration
	generate
		if (NUM_SRC < 1 || NUM_SRC > 32)
		begin : g_bad_count
			$error("two_level_interrupt_priority_ctrl: NUM_SRC out of range");
		end
		if (irq_prio_pkg::EXT0_IDX >= NUM_SRC)
		begin : g_bad_zero
			$error("two_level_interrupt_priority_ctrl: source zero index out of range");
		end
	endgenerate

endmodule : two_level_interrupt_priority_ctrl

// ---- irq_prio_monitor.sv ----
`timescale 1ns/1ps
// Port checks on the interrupt priority controller
module irq_prio_monitor #(
	parameter int NUM_SRC = 8
) (
	// Clock and reset
	input wire logic               clk,
	input wire logic               sys_rst,
	// Events and core handshake
	input wire logic [NUM_SRC-1:0] src_event,
	input wire logic               core_ack,
	input wire logic               return_from_irq_instr,
	input wire logic               irq_req,
	input wire logic [15:0]        irq_vector,
	// Status
	input wire logic [NUM_SRC-1:0] flag_q,
	input wire logic               priority_levels_enable,
	input wire logic               global_or_high_level_enable,
	input wire logic               peripheral_or_low_level_enable,
	input wire logic               in_high_service,
	input wire logic               in_low_service
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Fresh out of reset: no levels, no request
	reset_state_a: assert property ($past(sys_rst) |-> !priority_levels_enable && !irq_req)
		else $error("state after reset wrong");
	global_mask_a: assert property (!global_or_high_level_enable |-> !irq_req)
		else $error("request while globally masked");
	compat_vec_a: assert property (irq_req && $past(irq_req) && !$past(priority_levels_enable)
		|-> irq_vector == 16'h0008)
		else $error("compat vector wrong");
	flag_set_a: assert property (src_event != '0 |=> (flag_q & $past(src_event)) == $past(src_event))
		else $error("event did not set flag");
	// Acceptance clears the level enable
	ack_clear_a: assert property (core_ack && irq_req && !priority_levels_enable
		|=> !global_or_high_level_enable)
		else $error("global enable not cleared");
	low_ack_a: assert property (core_ack && irq_req && $past(irq_req) && priority_levels_enable
		&& irq_vector == 16'h0018 |=> !peripheral_or_low_level_enable && in_low_service)
		else $error("low acceptance wrong");
	high_only_a: assert property (in_high_service |=> irq_vector != 16'h0018)
		else $error("low offered in high routine");
	ret_high_a: assert property (return_from_irq_instr && in_high_service |=> global_or_high_level_enable)
		else $error("return left enable clear");
endmodule : irq_prio_monitor

bind two_level_interrupt_priority_ctrl irq_prio_monitor #(.NUM_SRC(NUM_SRC)) mon (.clk, .sys_rst, .src_event,
	.core_ack, .return_from_irq_instr, .irq_req, .irq_vector, .flag_q, .priority_levels_enable,
	.global_or_high_level_enable, .peripheral_or_low_level_enable, .in_high_service, .in_low_service);

// ---- core_model.sv ----
`timescale 1ns/1ps
// Core side: takes requests, issues returns on command
module core_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Offered request
	input  wire logic        irq_req,
	input  wire logic [15:0] irq_vector,
	// Bench controls
	input  wire logic        stall,
	input  wire logic        ret_cmd,
	// Handshake and what was taken
	output logic             core_ack,
	output logic             return_from_irq_instr,
	output logic             took,
	output logic [15:0]      vec_taken
);
	logic [1:0] age_q;

	// Ack only after two request cycles so the vector has settled
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			age_q <= 2'h0;
			core_ack <= 1'b0;
			return_from_irq_instr <= 1'b0;
			took <= 1'b0;
			vec_taken <= 16'h0000;
		end
		else
		begin
			age_q <= (irq_req && !core_ack) ? 2'h1 : 2'h0;
			core_ack <= irq_req && age_q != 2'h0 && !core_ack && !stall;
			return_from_irq_instr <= ret_cmd;
			took <= core_ack && irq_req;
			if (core_ack && irq_req)
				vec_taken <= irq_vector;
		end
	end
endmodule : core_model

// ---- two_level_interrupt_priority_ctrl_test.sv ----
`timescale 1ns/1ps
module two_level_interrupt_priority_ctrl_test;
	logic        clk = 1'b0, sys_rst = 1'b1, stall = 1'b0, ret_cmd = 1'b0;
	logic [7:0]  src_event = 8'h00, flag_clr = 8'h00, flag_set = 8'h00, enable_wdata = 8'h00, prio_wdata = 8'h00;
	logic        enable_wr = 1'b0, prio_wr = 1'b0, prio_en_wr = 1'b0, prio_en_wdata = 1'b0;
	logic        gen_wr = 1'b0, global_or_high_wdata = 1'b0, periph_or_low_wdata = 1'b0;
	logic        core_ack, return_from_irq_instr, irq_req, took, in_high_service, in_low_service;
	logic        priority_levels_enable, global_or_high_level_enable, peripheral_or_low_level_enable;
	logic [7:0]  flag_q, enable_q, prio_q;
	logic [15:0] irq_vector, vec_taken;
	int          num_errors = 0;
	int          n_checks = 0;

	// Clock, design and core
	always #2 clk = ~clk;
	two_level_interrupt_priority_ctrl dut (
		.clk(clk), .sys_rst(sys_rst), .src_event(src_event), .flag_clr(flag_clr), .flag_set(flag_set),
		.enable_wr(enable_wr), .enable_wdata(enable_wdata), .prio_wr(prio_wr), .prio_wdata(prio_wdata),
		.prio_en_wr(prio_en_wr), .prio_en_wdata(prio_en_wdata), .gen_wr(gen_wr),
		.global_or_high_wdata(global_or_high_wdata), .periph_or_low_wdata(periph_or_low_wdata),
		.core_ack(core_ack), .return_from_irq_instr(return_from_irq_instr), .irq_req(irq_req),
		.irq_vector(irq_vector), .flag_q(flag_q), .enable_q(enable_q), .prio_q(prio_q),
		.priority_levels_enable(priority_levels_enable),
		.global_or_high_level_enable(global_or_high_level_enable),
		.peripheral_or_low_level_enable(peripheral_or_low_level_enable),
		.in_high_service(in_high_service), .in_low_service(in_low_service)
	);
	core_model core (
		.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req), .irq_vector(irq_vector), .stall(stall), .ret_cmd(ret_cmd),
		.core_ack(core_ack), .return_from_irq_instr(return_from_irq_instr), .took(took), .vec_taken(vec_taken)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Wait for the core to take a request, then check its vector
	task automatic take(input logic [15:0] exp);
		int i;
		for (i = 0; i < 40 && took !== 1'b1; i++)
			tick(1);
		if (took !== 1'b1)
		begin
			num_errors++;
			$display("unexpected at %0t: no acceptance, got %h expected %h", $time, vec_taken, exp);
			results;
		end
		else
		begin
			chk(vec_taken, exp);
			tick(1);
		end
	endtask : take

	task automatic ev(input int n);
		src_event <= 8'h01 << n;
		tick(1);
		src_event <= 8'h00;
	endtask : ev

	task automatic gen(input logic g, input logic p);
		gen_wr <= 1'b1;
		global_or_high_wdata <= g;
		periph_or_low_wdata <= p;
		tick(1);
		gen_wr <= 1'b0;
	endtask : gen

	// Clear the flag, then return from the routine
	task automatic ret(input int n);
		flag_clr <= 8'h01 << n;
		ret_cmd <= 1'b1;
		tick(1);
		flag_clr <= 8'h00;
		ret_cmd <= 1'b0;
		tick(3);
	endtask : ret

	// Main sequence
	initial
	begin
		tick(4);
		sys_rst <= 1'b0;
		tick(2);
		chk({7'h00, priority_levels_enable, prio_q}, 16'h00ff);
		ev(2);
		tick(2);
		chk({7'h00, irq_req, flag_q}, 16'h0004);
		enable_wr <= 1'b1;
		enable_wdata <= 8'h24;
		tick(1);
		enable_wr <= 1'b0;
		gen(1'b1, 1'b0);
		take(16'h0008);
		chk(16'({in_high_service, in_low_service, enable_q}), 16'h0224);
		chk(16'(global_or_high_level_enable), 16'h0000);
		ret(2);
		chk(16'(global_or_high_level_enable), 16'h0001);
		flag_set <= 8'h20;
		tick(1);
		flag_set <= 8'h00;
		tick(3);
		chk(16'(irq_req), 16'h0000);
		gen(1'b1, 1'b1);
		take(16'h0008);
		ret(5);
		$display("compatibility test done");
		prio_en_wr <= 1'b1;
		prio_en_wdata <= 1'b1;
		prio_wr <= 1'b1;
		prio_wdata <= 8'h08;
		enable_wr <= 1'b1;
		enable_wdata <= 8'h0b;
		tick(1);
		prio_en_wr <= 1'b0;
		prio_wr <= 1'b0;
		enable_wr <= 1'b0;
		ev(1);
		take(16'h0018);
		chk(16'({in_low_service, peripheral_or_low_level_enable}), 16'h0002);
		ev(3);
		take(16'h0008);
		gen(1'b1, 1'b1);
		ev(1);
		tick(4);
		chk(16'(irq_req), 16'h0000);
		ret(3);
		ret(1);
		src_event <= 8'h0a;
		tick(1);
		src_event <= 8'h00;
		take(16'h0008);
		ret(3);
		take(16'h0018);
		ret(1);
		gen(1'b1, 1'b0);
		ev(1);
		tick(3);
		chk(16'(irq_req), 16'h0000);
		stall <= 1'b1;
		ev(0);
		tick(4);
		stall <= 1'b0;
		take(16'h0008);
		ret(0);
		gen(1'b0, 1'b1);
		tick(3);
		chk(16'(irq_req), 16'h0000);
		gen(1'b1, 1'b1);
		take(16'h0018);
		ret(1);
		$display("priority test done");
		results;
	end
endmodule : two_level_interrupt_priority_ctrl_test
